/* verilog/pioc_regs.sv */
/*
  Configuration register bank of a jitter-attenuating clock multiplier:
  loop bandwidth, input selection, hold, calibration squelch, history
  delay and output buffer format and drive.
  Assumes a decoded register port from the serial control logic on
  mclk; the priority and always-on bits come from the neighbouring
  registers on the same clock; selection pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pioc_defines.svh"
module pioc_regs
  import pioc_pkg::*;
#(
  parameter int CAL_CYCLES = `PIOC_CAL_CYCLES
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic cal_start,
  input wire logic always_on_output_bit,
  input wire logic [7:0] priority_fields,
  input wire logic [3:0] input_ok,
  input wire logic [1:0] selection_input_pins,
  input wire logic pin_select_flag,
  output logic [3:0] loop_bandwidth_active,
  output logic [4:0] history_delay_field,
  output logic [1:0] active_input,
  output logic digital_hold,
  output logic cal_busy,
  output logic clocks_running,
  output logic [1:0] buffer_enable,
  output logic [1:0] buffer_cmos,
  output logic [2:0] output_one_format_field,
  output logic [2:0] output_two_format_field,
  output logic [1:0] cmos_drive_field
);

  // ========================================================
  // Reset release
  // Async assert, clocked release, so no flop leaves reset alone
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ========================================================
  // State
  localparam pioc_top_s RST_S = '{
    r2: `PIOC_RST_BW,
    r3: `PIOC_RST_SEL,
    r4: `PIOC_RST_METH,
    r5: `PIOC_RST_FMT,
    bw_act: `PIOC_RST_BWACT,
    cal: PIOC_CAL_IDLE,
    cal_cnt: 16'h0000,
    rdata: 8'h00,
    run: 1'b1,
    buf_en: `PIOC_RST_BUFEN,
    buf_cmos: 2'h0
  };

  pioc_top_s s;
  pioc_top_s n;
  logic run_now;
  pioc_sel_if sif();

  // ========================================================
  // Helpers
  // Only writable bits take host data; the rest hold reset value
  function automatic logic [7:0] pioc_merge(input logic [7:0] d,
                                            input logic [7:0] m,
                                            input logic [7:0] r);
    return (d & m) | (r & ~m);
  endfunction

  // A buffer runs unless disabled or set to a reserved code
  function automatic logic pioc_fmt_on(input logic [2:0] f);
    return (f != `PIOC_FMT_DIS) && (f != `PIOC_FMT_RSV0) &&
           (f != `PIOC_FMT_RSV4);
  endfunction

  // ========================================================
  // Next state
  always_comb begin
    n = s;
    // host writes pass through the write masks
    if (reg_wr) begin
      case (reg_addr)
        `PIOC_OFS_BW: begin
          n.r2 = pioc_merge(reg_wdata, `PIOC_WM_BW, `PIOC_RST_BW);
        end
        `PIOC_OFS_SEL: begin
          n.r3 = pioc_merge(reg_wdata, `PIOC_WM_SEL, `PIOC_RST_SEL);
        end
        `PIOC_OFS_METH: begin
          n.r4 = pioc_merge(reg_wdata, `PIOC_WM_METH, `PIOC_RST_METH);
        end
        `PIOC_OFS_FMT: begin
          n.r5 = pioc_merge(reg_wdata, `PIOC_WM_FMT, `PIOC_RST_FMT);
        end
        default: begin
          n.r2 = s.r2;
        end
      endcase
    end
    // Read data is registered; a read in a write cycle sees old data
    case (reg_addr)
      `PIOC_OFS_BW: n.rdata = s.r2;
      `PIOC_OFS_SEL: n.rdata = s.r3;
      `PIOC_OFS_METH: n.rdata = s.r4;
      `PIOC_OFS_FMT: n.rdata = s.r5;
      default: n.rdata = 8'h00;
    endcase
    // calibration timer; bandwidth applied at its end
    case (s.cal)
      PIOC_CAL_IDLE: begin
        if (cal_start) begin
          n.cal = PIOC_CAL_RUN;
          n.cal_cnt = 16'(CAL_CYCLES - 1);
        end
      end
      PIOC_CAL_RUN: begin
        if (s.cal_cnt == 16'h0000) begin
          n.cal = PIOC_CAL_IDLE;
          n.bw_act = s.r2[`PIOC_BW];
        end else begin
          n.cal_cnt = s.cal_cnt - 16'h0001;
        end
      end
      default: begin
        n.cal = PIOC_CAL_IDLE;
      end
    endcase
    // squelch only while calibrating, unless forced on
    run_now = !((s.cal == PIOC_CAL_RUN) && s.r3[`PIOC_SQ] &&
                !always_on_output_bit);
    n.run = run_now;
    n.buf_en[0] = pioc_fmt_on(s.r5[`PIOC_F1]) && run_now;
    n.buf_en[1] = pioc_fmt_on(s.r5[`PIOC_F2]) && run_now;
    // drive strength applies to CMOS buffers only
    n.buf_cmos[0] = s.r5[`PIOC_F1] == `PIOC_FMT_CMOS;
    n.buf_cmos[1] = s.r5[`PIOC_F2] == `PIOC_FMT_CMOS;
  end

  // ========================================================
  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  // ========================================================
  // Selector hookup
  // method code drives the selector directly
  assign sif.method = pioc_meth_e'(s.r4[`PIOC_METH]);
  assign sif.man_sel = s.r3[`PIOC_MSEL];
  assign sif.hold_force = s.r3[`PIOC_HOLD];
  assign sif.prio = priority_fields;
  assign sif.in_ok = input_ok;

  pioc_select pioc_select_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .sel_pin(selection_input_pins),
    .pin_flag_pin(pin_select_flag),
    .sif(sif.sel)
  );

  // ========================================================
  // Outputs, all from flops
  assign reg_rdata = s.rdata;
  assign loop_bandwidth_active = s.bw_act;
  // history delay straight from the field
  assign history_delay_field = s.r4[`PIOC_HIST];
  assign active_input = sif.active;
  assign digital_hold = sif.in_hold;
  assign cal_busy = s.cal;
  assign clocks_running = s.run;
  assign buffer_enable = s.buf_en;
  assign buffer_cmos = s.buf_cmos;
  assign output_one_format_field = s.r5[`PIOC_F1];
  assign output_two_format_field = s.r5[`PIOC_F2];
  assign cmos_drive_field = s.r5[`PIOC_DRV];

  // ========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_bw_on_cal;
    $changed(s.bw_act) |-> ($past(s.cal) == PIOC_CAL_RUN) &&
                           ($past(s.cal_cnt) == 16'h0000);
  endproperty
  a_bw_on_cal: assert property (p_bw_on_cal)
    else $error("bandwidth changed outside calibration end");

  property p_squelch;
    (s.cal == PIOC_CAL_RUN && s.r3[`PIOC_SQ] && !always_on_output_bit)
      |=> !clocks_running && (buffer_enable == 2'h0);
  endproperty
  a_squelch: assert property (p_squelch)
    else $error("outputs not squelched during calibration");

  property p_no_squelch;
    (!s.r3[`PIOC_SQ] || s.cal == PIOC_CAL_IDLE) |=> clocks_running;
  endproperty
  a_no_squelch: assert property (p_no_squelch)
    else $error("outputs stopped without squelch");

  property p_always_on;
    always_on_output_bit |=> clocks_running;
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("always-on output was squelched");

  property p_out1_dis;
    (s.r5[`PIOC_F1] == `PIOC_FMT_DIS) |=> !buffer_enable[0];
  endproperty
  a_out1_dis: assert property (p_out1_dis)
    else $error("output one enabled while disabled");

  property p_out2_on;
    (s.r5[`PIOC_F2] == `PIOC_FMT_LVPECL && run_now) |=> buffer_enable[1];
  endproperty
  a_out2_on: assert property (p_out2_on)
    else $error("output two not enabled");

  property p_reserved;
    s.r2[`PIOC_RSV_BW] == 4'h2 && !s.r4[5] && s.r3[3:0] == 4'h5;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit changed");

  property p_cal_len;
    (s.cal == PIOC_CAL_IDLE && cal_start) |=>
      (s.cal == PIOC_CAL_RUN) && (s.cal_cnt == 16'(CAL_CYCLES - 1));
  endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration not loaded with its length");

  // A start while busy must not reload; the count only steps down
  property p_cal_step;
    (s.cal == PIOC_CAL_RUN && s.cal_cnt != 16'h0000) |=>
      (s.cal == PIOC_CAL_RUN) &&
      (s.cal_cnt == $past(s.cal_cnt) - 16'h0001);
  endproperty
  a_cal_step: assert property (p_cal_step)
    else $error("calibration count did not step down");

  property p_cal_end;
    (s.cal == PIOC_CAL_RUN && s.cal_cnt == 16'h0000) |=>
      !cal_busy && (loop_bandwidth_active == $past(s.r2[`PIOC_BW]));
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("bandwidth not applied at calibration end");

  property p_fmt_write;
    (reg_wr && reg_addr == `PIOC_OFS_FMT) |=>
      {cmos_drive_field, output_two_format_field,
       output_one_format_field} == $past(reg_wdata);
  endproperty
  a_fmt_write: assert property (p_fmt_write)
    else $error("format write did not land");

  property p_rd_unmapped;
    (reg_addr < `PIOC_OFS_BW || reg_addr > `PIOC_OFS_FMT) |=>
      reg_rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped offset read nonzero");

  c_squelch: cover property (s.cal == PIOC_CAL_RUN && !clocks_running);
  c_bw_apply: cover property ($changed(s.bw_act));
  c_hold: cover property (digital_hold && !s.r3[`PIOC_HOLD]);
  c_cmos: cover property (buffer_cmos == 2'h3);

endmodule
`default_nettype wire

/* verilog/pioc_defines.svh */
/*
  Offsets, reset values, write masks, field positions, format codes and
  timing counts of the PLL input/output configuration registers.
  Assumes it is included by bare name, after the timescale line.
*/
`ifndef PIOC_DEFINES_SVH
`define PIOC_DEFINES_SVH

// ==========================================================
// Register offsets on the control port
`define PIOC_OFS_BW 8'h02
`define PIOC_OFS_SEL 8'h03
`define PIOC_OFS_METH 8'h04
`define PIOC_OFS_FMT 8'h05

// ==========================================================
// Reset values
`define PIOC_RST_BW 8'h42
`define PIOC_RST_SEL 8'h05
`define PIOC_RST_METH 8'h12
`define PIOC_RST_FMT 8'hED
`define PIOC_RST_BWACT 4'h4
`define PIOC_RST_BUFEN 2'h3

// ==========================================================
// Writable bit masks; other bits are reserved and keep reset value
`define PIOC_WM_BW 8'hF0
`define PIOC_WM_SEL 8'hF0
`define PIOC_WM_METH 8'hDF
`define PIOC_WM_FMT 8'hFF

// ==========================================================
// Field positions
`define PIOC_BW 7:4
`define PIOC_MSEL 7:6
`define PIOC_HOLD 5
`define PIOC_SQ 4
`define PIOC_METH 7:6
`define PIOC_HIST 4:0
`define PIOC_DRV 7:6
`define PIOC_F2 5:3
`define PIOC_F1 2:0
`define PIOC_RSV_BW 3:0

// ==========================================================
// Output format codes
`define PIOC_FMT_RSV0 3'h0
`define PIOC_FMT_DIS 3'h1
`define PIOC_FMT_CMOS 3'h2
`define PIOC_FMT_LSLVDS 3'h3
`define PIOC_FMT_RSV4 3'h4
`define PIOC_FMT_LVPECL 3'h5
`define PIOC_FMT_CML 3'h6
`define PIOC_FMT_LVDS 3'h7

// ==========================================================
// Timing: internal calibration length in mclk cycles
`define PIOC_CAL_CYCLES 16

`endif

/* verilog/pioc_pkg.sv */
/*
  Types of the PLL input/output configuration block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pioc_pkg;

  // ========================================================
  // Selection method and calibration state
  typedef enum logic [1:0] {
    PIOC_MANUAL, PIOC_AUTO_NONREV, PIOC_AUTO_REV, PIOC_METH_RSVD
  } pioc_meth_e;

  typedef enum logic {PIOC_CAL_IDLE, PIOC_CAL_RUN} pioc_cal_e;

  // ========================================================
  // State of the input selector
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [1:0] pins;
    logic flag;
    logic [1:0] act;
    logic hold;
  } pioc_sel_s;

  // ========================================================
  // State of the register bank
  typedef struct packed {
    logic [7:0] r2;
    logic [7:0] r3;
    logic [7:0] r4;
    logic [7:0] r5;
    logic [3:0] bw_act;
    pioc_cal_e cal;
    logic [15:0] cal_cnt;
    logic [7:0] rdata;
    logic run;
    logic [1:0] buf_en;
    logic [1:0] buf_cmos;
  } pioc_top_s;

endpackage
`default_nettype wire

/* verilog/pioc_sel_if.sv */
/*
  Carrier between the register bank and the input selector.
  Assumes both ends share mclk and the synchronised reset.
*/
`timescale 1ns/1ps
`default_nettype none
interface pioc_sel_if;
  import pioc_pkg::*;
  pioc_meth_e method;
  logic [1:0] man_sel;
  logic hold_force;
  logic [7:0] prio;
  logic [3:0] in_ok;
  logic [1:0] active;
  logic in_hold;

  modport ctl(output method, man_sel, hold_force, prio, in_ok,
              input active, in_hold);
  modport sel(input method, man_sel, hold_force, prio, in_ok,
              output active, in_hold);
endinterface
`default_nettype wire

/* verilog/pioc_select.sv */
/*
  Input clock selector: manual by register or pins, automatic by
  priority, and forced digital hold.
  Assumes pins are asynchronous; all interface inputs are on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pioc_select
  import pioc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] sel_pin,
  input wire logic pin_flag_pin,
  pioc_sel_if.sel sif
);

  pioc_sel_s s;
  pioc_sel_s n;
  logic [2:0] best;

  // ========================================================
  // Best valid input by rank; rank one sits in the low bits
  function automatic logic [2:0] pioc_best(input logic [7:0] p,
                                           input logic [3:0] ok);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      if (ok[p[2*i +: 2]]) begin
        r = {1'b1, p[2*i +: 2]};
      end
    end
    return r;
  endfunction

  // ========================================================
  // Next state
  always_comb begin
    n = s;
    best = pioc_best(sif.prio, sif.in_ok);
    // Three stages; a change counts once stages two and three agree
    n.s1 = {pin_flag_pin, sel_pin};
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) begin
      n.pins = s.s3[1:0];
      n.flag = s.s3[2];
    end
    if (sif.hold_force) begin
      n.hold = 1'b1;
    end else begin
      case (sif.method)
        PIOC_MANUAL: begin
          n.hold = 1'b0;
          n.act = s.flag ? s.pins : sif.man_sel;
        end
        // revertive always takes the best rank
        PIOC_AUTO_REV: begin
          n.hold = !best[2];
          if (best[2]) begin
            n.act = best[1:0];
          end
        end
        // non-revertive stays while the input is good
        PIOC_AUTO_NONREV: begin
          if (!s.hold && sif.in_ok[s.act]) begin
            n.hold = 1'b0;
          end else begin
            n.hold = !best[2];
            if (best[2]) begin
              n.act = best[1:0];
            end
          end
        end
        // Reserved method freezes the selection
        default: begin
          n.hold = s.hold;
        end
      endcase
    end
  end

  // ========================================================
  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sif.active = s.act;
  assign sif.in_hold = s.hold;

  // ========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_force_hold;
    sif.hold_force |=> sif.in_hold;
  endproperty
  a_force_hold: assert property (p_force_hold)
    else $error("forced hold not entered");

  property p_man_reg;
    (sif.method == PIOC_MANUAL && !sif.hold_force && !s.flag)
      |=> (sif.active == $past(sif.man_sel)) && !sif.in_hold;
  endproperty
  a_man_reg: assert property (p_man_reg)
    else $error("manual register select not applied");

  property p_man_pin;
    (sif.method == PIOC_MANUAL && !sif.hold_force && s.flag)
      |=> sif.active == $past(s.pins);
  endproperty
  a_man_pin: assert property (p_man_pin)
    else $error("pin select not applied");

  property p_rev;
    (sif.method == PIOC_AUTO_REV && !sif.hold_force &&
     sif.in_ok[sif.prio[1:0]]) |=> sif.active == $past(sif.prio[1:0]);
  endproperty
  a_rev: assert property (p_rev)
    else $error("revertive did not take first rank");

endmodule
`default_nettype wire

/* verilog/pioc_end.sv */
`default_nettype wire

/* testbench/tb_pioc_regs.sv */
/*
  Self-checking bench for the PLL input/output configuration registers.
  Assumes the design files and the package are compiled first; the bench
  drives every port itself at the falling edge of mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pioc_regs
  import pioc_pkg::*;
;
  logic mclk, nrst, reg_wr, cal_start, always_on_output_bit;
  logic pin_select_flag, digital_hold, cal_busy, clocks_running;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, priority_fields;
  logic [3:0] input_ok, loop_bandwidth_active;
  logic [1:0] selection_input_pins, active_input, buffer_enable;
  logic [1:0] buffer_cmos, cmos_drive_field;
  logic [4:0] history_delay_field;
  logic [2:0] output_one_format_field, output_two_format_field;
  int mismatches, samples_checked;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int sel_q[$];
  localparam int S_RD = 0, S_BW = 1, S_HIST = 2, S_ACT = 3, S_HOLD = 4;
  localparam int S_BUSY = 5, S_CLK = 6, S_BEN = 7, S_BCM = 8, S_F1 = 9;
  localparam int S_F2 = 10, S_DRV = 11;

  // ==========================================================
  // Design under test, calibration shortened to keep the run brief
  pioc_regs #(.CAL_CYCLES(4)) pioc_regs_i (
    .mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cal_start(cal_start),
    .always_on_output_bit(always_on_output_bit),
    .priority_fields(priority_fields), .input_ok(input_ok),
    .selection_input_pins(selection_input_pins),
    .pin_select_flag(pin_select_flag),
    .loop_bandwidth_active(loop_bandwidth_active),
    .history_delay_field(history_delay_field),
    .active_input(active_input), .digital_hold(digital_hold),
    .cal_busy(cal_busy), .clocks_running(clocks_running),
    .buffer_enable(buffer_enable), .buffer_cmos(buffer_cmos),
    .output_one_format_field(output_one_format_field),
    .output_two_format_field(output_two_format_field),
    .cmos_drive_field(cmos_drive_field)
  );

  // ==========================================================
  // Clock, helpers and comparison
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Picks the output that a note refers to, widened to a byte
  function automatic logic [7:0] obs(input int s);
    case (s)
      S_RD: return reg_rdata;
      S_BW: return {4'h0, loop_bandwidth_active};
      S_HIST: return {3'h0, history_delay_field};
      S_ACT: return {6'h00, active_input};
      S_HOLD: return {7'h00, digital_hold};
      S_BUSY: return {7'h00, cal_busy};
      S_CLK: return {7'h00, clocks_running};
      S_BEN: return {6'h00, buffer_enable};
      S_BCM: return {6'h00, buffer_cmos};
      S_F1: return {5'h00, output_one_format_field};
      S_F2: return {5'h00, output_two_format_field};
      default: return {6'h00, cmos_drive_field};
    endcase
  endfunction

  // First ranked input that is usable; the order comes from the bench
  function automatic logic [1:0] best(input logic [3:0] ok);
    logic [1:0] idx;
    for (int r = 3; r >= 0; r--) begin
      idx = priority_fields[2*r +: 2];
      if (ok[idx]) best = idx;
    end
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic note(input int s, input logic [7:0] v);
    sel_q.push_back(s);
    exp_q.push_back(v);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One write strobe; the address stays so the byte reads back next
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    note(S_RD, e);
  endtask

  // A second start lands while busy; accepting it would stretch busy
  task automatic cal_run(input logic ao, input logic sq,
                         input logic [3:0] bw, input logic [3:0] old);
    always_on_output_bit = ao;
    wr(8'h03, {3'h0, sq, 4'h0});
    wr(8'h02, {bw, 4'h0});
    cyc(2);
    note(S_BW, old);
    cal_start = 1'b1;
    cyc(1);
    cal_start = 1'b0;
    cyc(1);
    note(S_BUSY, 8'h01);
    cyc(1);
    note(S_CLK, !(sq && !ao));
    note(S_BEN, (sq && !ao) ? 8'h00 : 8'h03);
    cal_start = 1'b1;
    cyc(1);
    cal_start = 1'b0;
    cyc(2);
    note(S_BUSY, 8'h00);
    note(S_BW, bw);
    cyc(1);
    note(S_CLK, 8'h01);
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // Monitor: settles past the falling edge, then pops each note
  initial begin
    int s;
    logic [7:0] e;
    forever begin
      @(negedge mclk);
      #1;
      while (exp_q.size() > 0) begin
        s = sel_q.pop_front();
        e = exp_q.pop_front();
        check(obs(s), e); // tag sits on each note
      end
    end
  end

  // Watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] rstv[4], wm[4], d;
    logic [3:0] ok;
    rstv = '{8'h42, 8'h05, 8'h12, 8'hED};
    wm = '{8'hF0, 8'hF0, 8'hDF, 8'hFF};
    mismatches = 0;
    samples_checked = 0;
    seed = 32'hF98C7C33;
    {nrst, reg_wr, cal_start, always_on_output_bit, pin_select_flag} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    priority_fields = 8'hE4;
    input_ok = 4'hF;
    selection_input_pins = 2'h0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    cyc(4);
    // Reset values of bank and outputs
    for (int i = 0; i < 4; i++) rd(8'(i + 2), rstv[i]);
    note(S_BW, 8'h04);
    note(S_HIST, 8'h12);
    note(S_F1, 8'h05);
    note(S_F2, 8'h05);
    note(S_DRV, 8'h03);
    note(S_CLK, 8'h01);
    note(S_BEN, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(8'(i + 2), 8'hFF);
      rd(8'(i + 2), wm[i] | (rstv[i] & ~wm[i]));
      wr(8'(i + 2), 8'h00);
      rd(8'(i + 2), rstv[i] & ~wm[i]);
    end
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    rd(8'h01, 8'h00);
    // Only two outputs exist here; formats swept freely
    for (int f = 0; f < 8; f++) begin
      seed = xs(seed);
      d = {seed[7:6], 3'(f), 3'(7 - f)};
      wr(8'h05, d);
      wr(8'h04, {3'h0, seed[12:8]});
      cyc(2);
      note(S_F1, 7 - f);
      note(S_F2, f);
      note(S_DRV, seed[7:6]);
      note(S_HIST, seed[12:8]);
      note(S_BEN, {f != 0 && f != 1 && f != 4,
                   f != 7 && f != 6 && f != 3});
      note(S_BCM, {f == 2, f == 5});
    end
    // Both outputs CMOS at once, drive code two
    wr(8'h05, 8'h92);
    cyc(2);
    note(S_BCM, 8'h03);
    note(S_DRV, 8'h02);
    note(S_BEN, 8'h03);
    wr(8'h05, 8'h3D);
    cal_run(1'b0, 1'b1, 4'hA, 4'h4);
    cal_run(1'b1, 1'b1, 4'h3, 4'hA);
    cal_run(1'b0, 1'b0, 4'hC, 4'h3);
    always_on_output_bit = 1'b0;
    // Manual register choice of all four inputs
    wr(8'h04, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h03, {2'(k), 6'h00});
      cyc(2);
      note(S_ACT, k);
      note(S_HOLD, 8'h00);
    end
    // Pins win over the register field
    pin_select_flag = 1'b1;
    selection_input_pins = 2'h2;
    wr(8'h03, 8'h40);
    cyc(8);
    note(S_ACT, 8'h02);
    selection_input_pins = 2'h1;
    wr(8'h03, 8'hC0);
    cyc(8);
    note(S_ACT, 8'h01);
    pin_select_flag = 1'b0;
    wr(8'h03, 8'h20);
    cyc(2);
    note(S_HOLD, 8'h01);
    wr(8'h03, 8'h00);
    cyc(2);
    note(S_HOLD, 8'h00);
    // Revertive choice by rank, none usable means hold
    priority_fields = 8'h1B;
    wr(8'h04, 8'h80);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      ok = (i == 0) ? 4'h0 : seed[3:0];
      input_ok = ok;
      cyc(3);
      note(S_HOLD, ok == 4'h0);
      if (ok != 4'h0) note(S_ACT, best(ok));
    end
    input_ok = 4'hF;
    cyc(3);
    wr(8'h04, 8'h40);
    input_ok = 4'h7;
    cyc(3);
    note(S_ACT, 8'h02);
    input_ok = 4'hF;
    cyc(3);
    note(S_ACT, 8'h02);
    wr(8'h04, 8'hC0);
    input_ok = 4'h1;
    cyc(3);
    note(S_ACT, 8'h02);
    cyc(3);
    conclude();
  end
endmodule
`default_nettype wire
